// ### sld_consts.svh
`ifndef SLD_CONSTS_SVH
`define SLD_CONSTS_SVH

// Register offsets on the plain register port
`define SLD_OFF_CTRL 8'h00
`define SLD_OFF_FLAGS 8'h01
`define SLD_OFF_ENABLES 8'h02
`define SLD_OFF_PRIORITY 8'h03
`define SLD_OFF_IRQ_STATUS 8'h04
`define SLD_OFF_IRQ_MASK 8'h05

// Control register fields
`define SLD_CTRL_LEVEL_LSB 0
`define SLD_CTRL_LEVEL_MSB 3
`define SLD_CTRL_PWR_BIT 4
`define SLD_CTRL_STABLE_BIT 5
`define SLD_LEVEL_EXTERNAL 4'hF

// Position of the supply-low bit in the flag, enable and priority registers
`define SLD_IRQ_BIT 2

// Reset values
`define SLD_CTRL_RESET 8'h05
`define SLD_FLAGS_RESET 8'h00
`define SLD_ENABLES_RESET 8'h00
`define SLD_PRIORITY_RESET 8'h00
`define SLD_IRQ_MASK_RESET 8'h00

// Reference settle time after power-up, in ns
`define SLD_SETTLE_NS 20000
`define SLD_CLK_NS 4

`endif

// ### sld_pkg.sv
package sld_pkg;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sld_req_s;

  // Detector power sequencing
  typedef enum logic [1:0] {
    SLD_OFF,
    SLD_SETTLING,
    SLD_READY
  } sld_state_e;

endpackage : sld_pkg

// ### sld_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous levels
module sld_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage read only by the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : sld_sync

// ### sld_ctrl.sv
`timescale 1ns/1ps
`include "sld_consts.svh"

// Contract
// RULE_01 - Comparator low sets the supply-low flag
// RULE_02 - Four-bit trip level selects sixteen taps
// RULE_03 - All-ones level routes external trip input
// RULE_04 - Enabled flag raises interrupt request
// RULE_05 - Software switches detector power on/off
// RULE_06 - Power enable lives at control bit 4
// RULE_07 - Read-only stable bit at control bit 5
// RULE_08 - Detector runs in sleep, wakes device
// RULE_09 - Reset returns registers, detector off
// RULE_10 - Flag sticky until software writes zero
module sld_ctrl
  import sld_pkg::*;
#(
  parameter int SETTLE_CYCLES = (`SLD_SETTLE_NS + `SLD_CLK_NS - 1) / `SLD_CLK_NS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic comp_low,
  input wire logic sleep_mode,
  input wire logic global_irq_enable,
  output logic detector_power_enable,
  output logic [3:0] trip_level_select,
  output logic external_trip_input_sel,
  output logic irq_request,
  output logic irq_high_priority,
  output logic wake_request,
  output logic irq
);

  // Settle count of zero would wrap the ready threshold to all ones
  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("SETTLE_CYCLES must be at least one");
  end

  // Reset image of the control register, mirrored by the level outputs
  localparam logic [7:0] CTRL_RESET_VAL = `SLD_CTRL_RESET;

  sld_req_s req;
  logic [1:0] pin_sync;
  logic comp_low_s;
  logic sleep_s;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Comparator and sleep come from outside the clock domain
  sld_sync #(.WIDTH(2)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({comp_low, sleep_mode}),
    .sync_out(pin_sync)
  );
  assign comp_low_s = pin_sync[1];
  assign sleep_s = pin_sync[0];

  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] enables_reg, enables_next;
  logic [7:0] priority_reg, priority_next;
  logic [7:0] irq_status_reg, irq_status_next;
  logic [7:0] irq_mask_reg, irq_mask_next;
  sld_state_e state_reg, state_next;
  logic [31:0] settle_cnt_reg, settle_cnt_next;
  logic stable;
  logic trip_event;
  logic [7:0] rdata_next;
  logic irq_req_next, prio_next, wake_next, irq_next;

  assign stable = (state_reg == SLD_READY); // see RULE_07
  // Flag sets only once the reference is stable
  assign trip_event = stable && comp_low_s; // see RULE_01

  // Power sequencing of the detector
  always_comb begin
    state_next = state_reg;
    settle_cnt_next = settle_cnt_reg;
    case (state_reg)
      SLD_OFF: begin
        settle_cnt_next = '0;
        if (ctrl_reg[`SLD_CTRL_PWR_BIT]) begin
          state_next = SLD_SETTLING; // see RULE_05
        end
      end
      SLD_SETTLING: begin
        if (!ctrl_reg[`SLD_CTRL_PWR_BIT]) begin
          state_next = SLD_OFF;
        end else if (settle_cnt_reg >= 32'(SETTLE_CYCLES - 1)) begin
          state_next = SLD_READY;
        end else begin
          settle_cnt_next = settle_cnt_reg + 32'd1;
        end
      end
      SLD_READY: begin
        if (!ctrl_reg[`SLD_CTRL_PWR_BIT]) begin
          state_next = SLD_OFF; // see RULE_05
        end
      end
      default: begin
        state_next = SLD_OFF;
      end
    endcase
  end

  // Register writes, sticky flag and interrupt status
  always_comb begin
    ctrl_next = ctrl_reg;
    flags_next = flags_reg;
    enables_next = enables_reg;
    priority_next = priority_reg;
    irq_status_next = irq_status_reg;
    irq_mask_next = irq_mask_reg;
    if (req.wr) begin
      case (req.addr)
        `SLD_OFF_CTRL: begin
          // Level and power writable, stable bit read-only
          ctrl_next = {3'b000, req.wdata[4:0]}; // see RULE_02
        end
        `SLD_OFF_FLAGS: flags_next = {4'h0, req.wdata[3:0]}; // see RULE_10
        `SLD_OFF_ENABLES: enables_next = {4'h0, req.wdata[3:0]};
        `SLD_OFF_PRIORITY: priority_next = {4'h0, req.wdata[3:0]};
        `SLD_OFF_IRQ_MASK: irq_mask_next = {4'h0, req.wdata[3:0]};
        default: begin
        end
      endcase
    end
    if (req.rd && req.addr == `SLD_OFF_IRQ_STATUS) begin
      irq_status_next = 8'h00;
    end
    // Set wins over clear, flag stays set after recovery
    if (trip_event) begin
      flags_next[`SLD_IRQ_BIT] = 1'b1; // see RULE_01, see RULE_10
      irq_status_next[`SLD_IRQ_BIT] = 1'b1;
    end
  end

  // Read data and outputs
  always_comb begin
    rdata_next = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `SLD_OFF_CTRL: begin
          rdata_next = ctrl_reg;
          rdata_next[`SLD_CTRL_STABLE_BIT] = stable; // see RULE_07
        end
        `SLD_OFF_FLAGS: rdata_next = flags_reg;
        `SLD_OFF_ENABLES: rdata_next = enables_reg;
        `SLD_OFF_PRIORITY: rdata_next = priority_reg;
        `SLD_OFF_IRQ_STATUS: rdata_next = irq_status_reg;
        `SLD_OFF_IRQ_MASK: rdata_next = irq_mask_reg;
        default: rdata_next = 8'h00;
      endcase
    end
    irq_req_next = flags_next[`SLD_IRQ_BIT] && enables_next[`SLD_IRQ_BIT]
                   && global_irq_enable; // see RULE_04, see RULE_08
    prio_next = priority_next[`SLD_IRQ_BIT];
    // Wake from sleep regardless of the global enable
    wake_next = sleep_s && flags_next[`SLD_IRQ_BIT] && enables_next[`SLD_IRQ_BIT]; // see RULE_08
    irq_next = |(irq_status_next & irq_mask_next);
  end

  // All state registers; reset leaves the detector off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `SLD_CTRL_RESET; // see RULE_09
      flags_reg <= `SLD_FLAGS_RESET;
      enables_reg <= `SLD_ENABLES_RESET;
      priority_reg <= `SLD_PRIORITY_RESET;
      irq_status_reg <= 8'h00;
      irq_mask_reg <= `SLD_IRQ_MASK_RESET;
      state_reg <= SLD_OFF;
      settle_cnt_reg <= '0;
      reg_rdata <= 8'h00;
      irq_request <= 1'b0;
      irq_high_priority <= 1'b0;
      wake_request <= 1'b0;
      irq <= 1'b0;
      detector_power_enable <= 1'b0;
      trip_level_select <= CTRL_RESET_VAL[`SLD_CTRL_LEVEL_MSB:`SLD_CTRL_LEVEL_LSB]; // see RULE_09
      external_trip_input_sel <= (CTRL_RESET_VAL[`SLD_CTRL_LEVEL_MSB:`SLD_CTRL_LEVEL_LSB] == `SLD_LEVEL_EXTERNAL);
    end else begin
      ctrl_reg <= ctrl_next;
      flags_reg <= flags_next;
      enables_reg <= enables_next;
      priority_reg <= priority_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      state_reg <= state_next;
      settle_cnt_reg <= settle_cnt_next;
      reg_rdata <= rdata_next;
      irq_request <= irq_req_next;
      irq_high_priority <= prio_next;
      wake_request <= wake_next;
      irq <= irq_next;
      detector_power_enable <= ctrl_next[`SLD_CTRL_PWR_BIT]; // see RULE_06
      trip_level_select <= ctrl_next[`SLD_CTRL_LEVEL_MSB:`SLD_CTRL_LEVEL_LSB]; // see RULE_02
      external_trip_input_sel <= ctrl_next[`SLD_CTRL_LEVEL_MSB:`SLD_CTRL_LEVEL_LSB]
                                 == `SLD_LEVEL_EXTERNAL; // see RULE_03
    end
  end

  // Assertions
  a_flag_sets: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_01
    trip_event |=> flags_reg[`SLD_IRQ_BIT])
    else $error("trip did not set flag");

  a_flag_stable_only: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_01
    (!stable && !flags_reg[`SLD_IRQ_BIT] && !(req.wr && req.addr == `SLD_OFF_FLAGS)) |=> !flags_reg[`SLD_IRQ_BIT])
    else $error("flag set before reference stable");

  a_level_out: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_02
    trip_level_select == ctrl_reg[3:0])
    else $error("trip level output mismatch");

  a_level_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_02
    (req.wr && req.addr == `SLD_OFF_CTRL) |=> trip_level_select == $past(req.wdata[3:0]))
    else $error("trip level not written");

  a_ext_select: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_03
    external_trip_input_sel == (trip_level_select == 4'hF))
    else $error("external select wrong");

  a_irq_raise: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_04
    (trip_event && enables_reg[`SLD_IRQ_BIT] && global_irq_enable && !(req.wr && req.addr == `SLD_OFF_ENABLES))
    |=> irq_request)
    else $error("irq not raised");

  a_irq_gated: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_04
    irq_request |-> flags_reg[`SLD_IRQ_BIT] && enables_reg[`SLD_IRQ_BIT] && $past(global_irq_enable))
    else $error("irq request without cause");

  a_prio_out: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_04
    irq_high_priority == priority_reg[`SLD_IRQ_BIT])
    else $error("priority output mismatch");

  a_status_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_04
    trip_event |=> irq_status_reg[`SLD_IRQ_BIT])
    else $error("trip did not set status");

  a_status_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_04
    (irq_status_reg[`SLD_IRQ_BIT] && !(req.rd && req.addr == `SLD_OFF_IRQ_STATUS)) |=> irq_status_reg[`SLD_IRQ_BIT])
    else $error("status dropped without read");

  a_status_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_04
    (req.rd && req.addr == `SLD_OFF_IRQ_STATUS && !trip_event) |=> irq_status_reg == 8'h00)
    else $error("status not cleared by read");

  a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_04
    irq == |(irq_status_reg & irq_mask_reg))
    else $error("interrupt level mismatch");

  a_power_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_05
    !detector_power_enable |=> state_reg == SLD_OFF)
    else $error("detector running while off");

  a_settle_start: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_05
    (state_reg == SLD_OFF && ctrl_reg[`SLD_CTRL_PWR_BIT]) |=> state_reg == SLD_SETTLING)
    else $error("settling did not start");

  a_power_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_06
    (req.wr && req.addr == `SLD_OFF_CTRL) |=> detector_power_enable == $past(req.wdata[4]))
    else $error("power bit not written");

  a_power_level: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_06
    detector_power_enable == ctrl_reg[`SLD_CTRL_PWR_BIT])
    else $error("power output mismatch");

  a_stable_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_07
    (req.rd && req.addr == `SLD_OFF_CTRL) |=> reg_rdata[5] == $past(stable))
    else $error("stable bit read wrong");

  a_ready_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_07
    (state_reg == SLD_SETTLING && ctrl_reg[`SLD_CTRL_PWR_BIT] && settle_cnt_reg == 32'(SETTLE_CYCLES - 1)) |=> stable)
    else $error("reference not ready after settling");

  a_not_ready_early: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_07
    (state_reg == SLD_SETTLING && settle_cnt_reg < 32'(SETTLE_CYCLES - 1)) |=> !stable)
    else $error("reference ready too early");

  a_ctrl_upper: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_07
    ctrl_reg[7:6] == 2'b00 && !ctrl_reg[`SLD_CTRL_STABLE_BIT])
    else $error("read-only control bits stored");

  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_07
    !req.rd |=> reg_rdata == 8'h00)
    else $error("read data without read");

  a_wake_sleep: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_08
    wake_request |-> flags_reg[`SLD_IRQ_BIT] && enables_reg[`SLD_IRQ_BIT])
    else $error("spurious wake");

  a_wake_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_08
    wake_request |-> $past(sleep_s))
    else $error("wake while awake");

  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_10
    (flags_reg[`SLD_IRQ_BIT] && !(req.wr && req.addr == `SLD_OFF_FLAGS)) |=> flags_reg[`SLD_IRQ_BIT])
    else $error("flag dropped without write");

  a_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE_10
    (req.wr && req.addr == `SLD_OFF_FLAGS && !req.wdata[`SLD_IRQ_BIT] && !trip_event) |=> !flags_reg[`SLD_IRQ_BIT])
    else $error("flag not cleared by write");

endmodule : sld_ctrl

// ### tb_top.sv
`timescale 1ns/1ps
`include "sld_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end

module tb_top
  import sld_pkg::*;
;
  logic sys_clk, rst_n, reg_wr, reg_rd, comp_low, sleep_mode, global_irq_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic detector_power_enable, external_trip_input_sel, irq_request, irq_high_priority, wake_request, irq;
  logic [3:0] trip_level_select;
  int err_total = 0;
  int cmp_count = 0;
  int mdl[6];
  logic [31:0] seed = 32'h8AF354BB;

  sld_ctrl #(.SETTLE_CYCLES(8)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comp_low(comp_low), .sleep_mode(sleep_mode), .global_irq_enable(global_irq_enable),
    .detector_power_enable(detector_power_enable), .trip_level_select(trip_level_select),
    .external_trip_input_sel(external_trip_input_sel), .irq_request(irq_request),
    .irq_high_priority(irq_high_priority), .wake_request(wake_request), .irq(irq));

  // Free-running core clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  // One-cycle write strobe, outputs settled on return
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd

  // Raise the comparator long enough to pass the synchroniser
  task automatic trip();
    @(posedge sys_clk);
    comp_low <= 1'b1;
    repeat (4) @(posedge sys_clk);
    comp_low <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : trip

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    mdl = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  endtask : do_reset

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    conclude();
  end

  initial begin
    {reg_wr, reg_rd, comp_low, sleep_mode, global_irq_enable} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    do_reset();
    // Reset values, unmapped place reads zero
    for (int i = 0; i < 6; i++) begin
      rd(i[7:0]);
      `CHK(rd_val, mdl[i][7:0])
    end
    rd(8'h07);
    `CHK(rd_val, 8'h00)
    `CHK(detector_power_enable, 1'b0)
    // Every level code; bits 7:5 are not writable, stable bit masked from the check
    for (int i = 0; i < 16; i++) begin
      wr(`SLD_OFF_CTRL, 8'hF0 | i[7:0]);
      `CHK(trip_level_select, i[3:0])
      `CHK(external_trip_input_sel, (i == 15))
      `CHK(detector_power_enable, 1'b1)
      rd(`SLD_OFF_CTRL);
      `CHK(rd_val & 8'hDF, 8'h10 | i[7:0])
    end
    // Power off then on, stable bit after settling
    wr(`SLD_OFF_CTRL, 8'h05);
    `CHK(detector_power_enable, 1'b0)
    rd(`SLD_OFF_CTRL);
    `CHK(rd_val, 8'h05)
    wr(`SLD_OFF_CTRL, 8'h15);
    repeat (14) @(posedge sys_clk);
    rd(`SLD_OFF_CTRL);
    `CHK(rd_val, 8'h35)
    // Random plain bits in enable and priority registers
    for (int i = 0; i < 6; i++) begin
      rd_val = 8'(xorshift());
      mdl[2 + i % 2] = rd_val & 8'h0F;
      wr(8'(`SLD_OFF_ENABLES + i % 2), rd_val);
      rd(8'(`SLD_OFF_ENABLES + i % 2));
      `CHK(rd_val, mdl[2 + i % 2][7:0])
    end
    wr(`SLD_OFF_PRIORITY, 8'h04);
    `CHK(irq_high_priority, 1'b1)
    // Trip with interrupt enabled, flag sticky
    wr(`SLD_OFF_ENABLES, 8'h04);
    wr(`SLD_OFF_IRQ_MASK, 8'h04);
    global_irq_enable <= 1'b1;
    `CHK(irq, 1'b0)
    trip();
    `CHK(irq_request, 1'b1)
    `CHK(irq, 1'b1)
    rd(`SLD_OFF_FLAGS);
    `CHK(rd_val, 8'h04)
    rd(`SLD_OFF_IRQ_STATUS);
    `CHK(rd_val, 8'h04)
    rd(`SLD_OFF_IRQ_STATUS);
    `CHK(rd_val, 8'h00)
    `CHK(irq, 1'b0)
    `CHK(irq_request, 1'b1)
    wr(`SLD_OFF_FLAGS, 8'h00);
    `CHK(irq_request, 1'b0)
    // Sleep trip wakes without global enable
    global_irq_enable <= 1'b0;
    sleep_mode <= 1'b1;
    trip();
    `CHK(wake_request, 1'b1)
    `CHK(irq_request, 1'b0)
    wr(`SLD_OFF_FLAGS, 8'h00);
    `CHK(wake_request, 1'b0)
    sleep_mode <= 1'b0;
    // Mid-run reset switches detector off
    do_reset();
    `CHK(detector_power_enable, 1'b0)
    `CHK(irq_high_priority, 1'b0)
    rd(`SLD_OFF_CTRL);
    `CHK(rd_val, 8'h05)
    rd(`SLD_OFF_ENABLES);
    `CHK(rd_val, 8'h00)
    conclude();
  end
endmodule : tb_top
